// ==== verilog/mcr_defs.vh ====
// Offsets, field positions, selector codes and index ranges of the counter read block
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH
`define MCR_OFS_CTRL        8'h79
`define MCR_OFS_TRIG        8'h7a
`define MCR_OFS_DATA3       8'h80
`define MCR_OFS_DATA2       8'h81
`define MCR_OFS_DATA1       8'h82
`define MCR_OFS_DATA0       8'h83
`define MCR_SEL_PORT        8'h1c
`define MCR_SEL_DROP        8'h1d
`define MCR_BIT_OVF         7
`define MCR_BIT_VALID       6
`define MCR_CTRL_RST        8'h00
`define MCR_TRIG_RST        8'h00
`define MCR_PORT_CNTS       32
`define MCR_PORTS           3
`define MCR_PORT_WORDS      96
`define MCR_DROP_CNTS       6
`define MCR_DROP_BASE       9'h100
`define MCR_CNT_W           30
`define MCR_DROP_W          16
`define MCR_WORD_W          31
`define MCR_VALID_DLY       2'h2
`define MCR_PORT_IDX_END    8'h60
`define MCR_INC_MAX         7'h60
`endif

// ==== verilog/mcr_counter_ram.v ====
// Per-port counter storage, one overflow bit plus 30 count bits per word
`timescale 1ns/10ps
module mcr_counter_ram (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [6:0]  rd_addr,
  output reg  [30:0] rd_data,
  input  wire        wr_en,
  input  wire [6:0]  wr_addr,
  input  wire [30:0] wr_data
);
  reg [30:0] mem [0:95];
  integer i;

  // Registered read; write port serves both clear-on-read and counting
  always @(posedge ref_clk) begin
    if (reset) begin
      for (i = 0; i < 96; i = i + 1)
        mem[i] <= 31'h0;
      rd_data <= 31'h0;
    end else begin
      rd_data <= mem[rd_addr];
      if (wr_en)
        mem[wr_addr] <= wr_data;
    end
  end
endmodule

// ==== verilog/mcr_stat_read.v ====
// Indirect statistics counter read block with host register port
`timescale 1ns/10ps
`include "mcr_defs.vh"
module mcr_stat_read (
  input  wire       ref_clk,
  input  wire       reset,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_q,
  input  wire [6:0] port_inc,
  input  wire [5:0] drop_inc,
  output reg        read_busy_q
);
  // One-hot sequencer for the per-port fetch; dropped reads need no sequence
  localparam ST_IDLE  = 3'b001;
  localparam ST_FETCH = 3'b010;
  localparam ST_CLEAR = 3'b100;

  reg  [7:0]  ctrl_q;
  reg  [7:0]  trig_q;
  reg  [2:0]  state_q;
  reg  [6:0]  rd_idx_q;
  reg         drop_sel_q;
  reg         valid_q;
  reg         ovf_q;
  reg  [29:0] snap_q;
  reg  [15:0] drop_cnt_q [0:5];
  reg  [6:0]  scan_q;
  wire [30:0] ram_rd;
  reg         ram_we;
  reg  [6:0]  ram_wa;
  reg  [30:0] ram_wd;
  reg  [6:0]  ram_ra;
  reg  [30:0] inc_base;
  reg         last_we_q;
  reg  [6:0]  last_wa_q;
  reg  [30:0] last_wd_q;
  wire        inc_ok;
  wire [6:0]  inc_word;

  // Port index from trigger: each port spans 32 offsets
  function [6:0] port_word;
    input [7:0] idx;
    begin
      port_word = {idx[6:5], idx[4:0]};
    end
  endfunction

  // Write strobe aimed at one register offset
  function reg_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = wr && (addr == ofs);
    end
  endfunction

  // Increment request names word plus one; codes past the last word are dropped
  assign inc_ok   = (port_inc != 7'h00) && (port_inc <= `MCR_INC_MAX);
  assign inc_word = inc_ok ? port_inc - 7'h01 : 7'h00;

  mcr_counter_ram u_ram (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rd_addr (ram_ra),
    .rd_data (ram_rd),
    .wr_en   (ram_we),
    .wr_addr (ram_wa),
    .wr_data (ram_wd)
  );

  // Host register writes and trigger sequencing
  // Triggers while busy are ignored, so one snapshot is never torn in two
  always @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q      <= `MCR_CTRL_RST;
      trig_q      <= `MCR_TRIG_RST;
      state_q     <= ST_IDLE;
      rd_idx_q    <= 7'h00;
      drop_sel_q  <= 1'b0;
      valid_q     <= 1'b0;
      ovf_q       <= 1'b0;
      snap_q      <= 30'h0;
      read_busy_q <= 1'b0;
    end else begin
      if (reg_hit(reg_wr, reg_addr, `MCR_OFS_CTRL))
        ctrl_q <= reg_wdata;
      case (state_q)
        ST_IDLE: begin
          read_busy_q <= 1'b0;
          if (reg_hit(reg_wr, reg_addr, `MCR_OFS_TRIG)) begin
            trig_q <= reg_wdata;
            if (ctrl_q == `MCR_SEL_DROP) begin
              // Dropped class: immediate snapshot, counter untouched
              drop_sel_q <= 1'b1;
              valid_q    <= 1'b0;
              ovf_q      <= 1'b0;
              snap_q     <= (reg_wdata < `MCR_DROP_CNTS) ?
                            {14'h0, drop_cnt_q[reg_wdata[2:0]]} : 30'h0;
            end else if (ctrl_q == `MCR_SEL_PORT && reg_wdata < `MCR_PORT_IDX_END) begin
              // Per-port class: fetch word, then snapshot and clear it on the same edge
              drop_sel_q  <= 1'b0;
              rd_idx_q    <= port_word(reg_wdata);
              valid_q     <= 1'b0;
              read_busy_q <= 1'b1;
              state_q     <= ST_FETCH;
            end
          end
        end
        ST_FETCH: begin
          state_q <= ST_CLEAR;
        end
        ST_CLEAR: begin
          // Capture overflow and value, raise valid
          ovf_q       <= ram_rd[30];
          snap_q      <= ram_rd[29:0];
          valid_q     <= 1'b1;
          read_busy_q <= 1'b0;
          state_q     <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Memory port: the fetch owns the read port outside idle, the clear owns the write port
  // Limitation: increments offered during the two fetch cycles are not counted
  always @* begin
    ram_ra   = (state_q == ST_IDLE) ? inc_word : rd_idx_q;
    // Forward the last write, since the registered read cannot see it yet
    inc_base = (last_we_q && last_wa_q == scan_q - 7'h01) ? last_wd_q : ram_rd;
    ram_we   = 1'b0;
    ram_wa   = scan_q - 7'h01;
    ram_wd   = 31'h0;
    if (state_q == ST_CLEAR) begin
      ram_we = 1'b1;
      ram_wa = rd_idx_q;
      ram_wd = 31'h0;
    end else if (scan_q != 7'h00) begin
      // Overflow stays set until the read clears it
      ram_we = 1'b1;
      ram_wd = {inc_base[30] | (&inc_base[29:0]), inc_base[29:0] + 30'h1};
    end
  end

  // Increment scan pointer holds word plus one, zero when no read was issued
  always @(posedge ref_clk) begin
    if (reset)
      scan_q <= 7'h00;
    else if (state_q == ST_IDLE && inc_ok)
      scan_q <= port_inc;
    else
      scan_q <= 7'h00;
  end

  // Record each write so back-to-back increments of one word all count
  always @(posedge ref_clk) begin
    if (reset) begin
      last_we_q <= 1'b0;
      last_wa_q <= 7'h00;
      last_wd_q <= 31'h0;
    end else begin
      last_we_q <= ram_we;
      last_wa_q <= ram_wa;
      last_wd_q <= ram_wd;
    end
  end

  // Dropped counters wrap silently; host tracks wrap
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_drop
      always @(posedge ref_clk) begin
        if (reset)
          drop_cnt_q[g] <= 16'h0;
        else if (drop_inc[g])
          drop_cnt_q[g] <= drop_cnt_q[g] + 16'h1;
      end
    end
  endgenerate

  // Read mux over the documented offsets, unmapped reads return zero
  // The two high data bytes (flags and bits 29:16) read zero for the dropped class, which carries no flags
  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MCR_OFS_CTRL:  reg_rdata_q <= ctrl_q;
        `MCR_OFS_TRIG:  reg_rdata_q <= trig_q;
        `MCR_OFS_DATA3: reg_rdata_q <= drop_sel_q ? 8'h00 : {ovf_q, valid_q, snap_q[29:24]};
        `MCR_OFS_DATA2: reg_rdata_q <= drop_sel_q ? 8'h00 : snap_q[23:16];
        `MCR_OFS_DATA1: reg_rdata_q <= snap_q[15:8];
        `MCR_OFS_DATA0: reg_rdata_q <= snap_q[7:0];
        default:        reg_rdata_q <= 8'h00;
      endcase
    end
  end
endmodule

// ==== testbench/mcr_stat_read_asserts.sv ====
// Checker on the ports of the counter read block
`timescale 1ns/10ps
module mcr_chk (
  input wire       ref_clk,
  input wire       reset,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire       read_busy_q
);
  reg  [7:0] sel_q;
  reg        drop_q;
  wire       trig = reg_wr && reg_addr == 8'h7a && !read_busy_q;
  wire       pt = trig && sel_q == 8'h1c && reg_wdata < 8'h60;
  // Shadow selector and snapshot class; busy triggers are ignored
  always @(posedge ref_clk) begin
    if (reset) begin
      sel_q  <= 8'h00;
      drop_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h79)
        sel_q <= reg_wdata;
      if (pt || trig && sel_q == 8'h1d)
        drop_q <= !pt;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_port_fetch: assert property (pt |=> read_busy_q ##1 read_busy_q ##1 !read_busy_q)
    else $error("port fetch timing");
  a_busy_bound: assert property (read_busy_q |-> ##[1:2] !read_busy_q)
    else $error("busy too long");
  a_drop_idle: assert property (trig && sel_q == 8'h1d |=> !read_busy_q)
    else $error("drop fetch busy");
  a_bad_sel: assert property (trig && sel_q != 8'h1c && sel_q != 8'h1d |=> !read_busy_q)
    else $error("bad selector fetched");
  a_drop_flags: assert property (reg_rd && reg_addr[7:1] == 7'h40 && drop_q |=> reg_rdata_q == 8'h00)
    else $error("drop high bytes");
  a_not_valid: assert property (reg_rd && reg_addr == 8'h80 && read_busy_q |=> !reg_rdata_q[6])
    else $error("valid while busy");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved");
  a_reset_out: assert property (disable iff (1'b0) reset |=> reg_rdata_q == 8'h00 && !read_busy_q)
    else $error("outputs not cleared");
endmodule
bind mcr_stat_read mcr_chk chk (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .read_busy_q(read_busy_q));

// ==== testbench/mcr_host.sv ====
// Host model driving the register port
`timescale 1ns/10ps
module mcr_host (
  input  wire       ref_clk,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata_q
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h0;
  // One-cycle write strobe; selector always goes before trigger
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge ref_clk) #1 reg_wr = 1'b0;
    end
  endtask
  // Read data is registered, so it is taken one edge after the strobe
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge ref_clk) #1 {reg_rd, reg_addr} = {1'b1, a};
      @(posedge ref_clk) #1 reg_rd = 1'b0;
      d = reg_rdata_q;
    end
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the counter read block
`timescale 1ns/10ps
module tb;
  reg        ref_clk = 1'b0;
  reg        reset = 1'b1;
  reg  [6:0] port_inc = 7'h00;
  reg  [5:0] drop_inc = 6'h00;
  reg  [7:0] d;
  wire       reg_wr, reg_rd, read_busy_q;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  integer    bad_count = 0, cmp_count = 0, i;
  initial forever #2 ref_clk = ~ref_clk;
  mcr_stat_read uut (.ref_clk(ref_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .port_inc(port_inc), .drop_inc(drop_inc),
    .read_busy_q(read_busy_q));
  mcr_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [7:0] exp);
    begin
      host.rd(a, d);
      chk(d, exp);
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Select, trigger, then poll the flag byte until valid (per-port only)
  task fetch(input [7:0] sel, input [7:0] idx);
    begin
      host.wr(8'h79, sel);
      host.wr(8'h7a, idx);
      chk({7'h00, read_busy_q}, {7'h00, sel == 8'h1c});
      d = 8'h00;
      for (i = 0; i < 8 && sel == 8'h1c && d[6] !== 1'b1; i = i + 1)
        host.rd(8'h80, d);
      if (i == 8) begin
        bad_count = bad_count + 1;
        report_and_stop;
      end
    end
  endtask
  // Count n events, read twice; the second read finds it cleared
  task t_port(input [7:0] idx, input [15:0] n);
    begin
      repeat (n) @(posedge ref_clk) #1 port_inc = idx[6:0] + 7'h01;
      @(posedge ref_clk) #1 port_inc = 7'h00;
      fetch(8'h1c, idx);
      chk(d, 8'h40);
      rchk(8'h81, 8'h00);
      rchk(8'h82, n[15:8]);
      rchk(8'h83, n[7:0]);
      fetch(8'h1c, idx);
      rchk(8'h83, 8'h00);
      $display("port test %h done", idx);
    end
  endtask
  // Drop count 0x102 must survive two reads, flags stay zero
  task t_drop;
    begin
      repeat (258) @(posedge ref_clk) #1 drop_inc = 6'h01;
      @(posedge ref_clk) #1 drop_inc = 6'h00;
      repeat (2) begin
        fetch(8'h1d, 8'h00);
        rchk(8'h80, 8'h00);
        rchk(8'h82, 8'h01);
        rchk(8'h83, 8'h02);
      end
      $display("drop test done");
    end
  endtask
  // Refused triggers start no fetch; control and trigger registers read back
  task t_refuse;
    begin
      host.wr(8'h79, 8'h55);
      rchk(8'h79, 8'h55);
      host.wr(8'h7a, 8'h0e);
      chk({7'h00, read_busy_q}, 8'h00);
      host.wr(8'h79, 8'h1c);
      host.wr(8'h7a, 8'h60);
      chk({7'h00, read_busy_q}, 8'h00);
      rchk(8'h7a, 8'h60);
      $display("refuse test done");
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 reset = 1'b0;
    t_port(8'h2e, 16'd300);
    t_port(8'h0e, 16'd1);
    t_drop;
    t_refuse;
    report_and_stop;
  end
endmodule
